// ===== include/pmcap_pkg.sv
// package with offsets, field layouts, reset values and carrier types of the power-management capability
package pmcap_pkg;

	// ==========================================================
	// configuration byte offsets
	localparam logic [7:0] CAP_ID_OFFSET = 8'h50;
	localparam logic [7:0] NEXT_PTR_OFFSET = 8'h51;
	localparam logic [7:0] CAPS_OFFSET = 8'h52;
	localparam logic [7:0] CTRL_STATUS_OFFSET = 8'h54;

	// dword indices seen on the config port (offset bits 7:2)
	localparam logic [5:0] DW_CAP = CAP_ID_OFFSET[7:2];
	localparam logic [5:0] DW_CTRL = CTRL_STATUS_OFFSET[7:2];

	// ==========================================================
	// fixed values and reset values
	localparam logic [7:0] CAP_ID_VALUE = 8'h01;
	localparam logic [7:0] NEXT_PTR_VALUE = 8'h60;
	localparam logic [4:0] WAKE_SOURCE_STATES_VALUE = 5'h00;
	localparam logic [2:0] AUX_CURRENT_VALUE = 3'h0;
	localparam logic [2:0] REVISION_BASE = 3'h2;
	localparam logic [2:0] REVISION_SELECTED = 3'h3;
	localparam logic [15:0] CAPS_RESET = 16'h0603;
	localparam logic [15:0] CTRL_STATUS_RESET = 16'h0008;
	localparam logic WAKE_ENABLE_RESET = 1'b0;

	// ==========================================================
	// field positions
	localparam int CAPS_WAKE_SRC_LSB = 11;
	localparam int CAPS_LOW2_BIT = 10;
	localparam int CAPS_LOW1_BIT = 9;
	localparam int CAPS_AUX_LSB = 6;
	localparam int CAPS_DSI_BIT = 5;
	localparam int CAPS_WAKE_CLK_BIT = 3;
	localparam int CAPS_REV_LSB = 0;
	localparam int CS_STATE_LSB = 0;
	localparam int CS_NO_SOFT_RESET_BIT = 3;
	localparam int CS_SCRATCH_BIT = 8;
	localparam int CS_WAKE_STATUS_BIT = 15;

	// ==========================================================
	// power states
	typedef enum logic [1:0] {
		PS_FULL_ON = 2'b00,
		PS_LOW1 = 2'b01,
		PS_LOW2 = 2'b10,
		PS_HOT_OFF = 2'b11
	} pmcap_power_state_e;

	// configuration access request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [5:0] dwAddr;
		logic [3:0] byteEn;
		logic [31:0] wrData;
	} pmcap_cfg_req_s;

endpackage : pmcap_pkg

// ===== rtl/pmcap_word_compose.sv
// combinational assembly of the capabilities word and the control/status readback
`timescale 1ns/1ps

module pmcap_word_compose
	import pmcap_pkg::*;
(
	// control inputs
	input wire logic revisionSelect,
	input wire pmcap_power_state_e powerState,
	input wire logic wakeEnableScratch,
	// assembled words
	output logic [15:0] capsWord,
	output logic [15:0] ctrlStatusWord
);

	// ==========================================================
	// capabilities word
	wire logic [2:0] revision = revisionSelect ? REVISION_SELECTED : REVISION_BASE;

	// constant fields are wired, never stored, so no write can reach them
	assign capsWord = {WAKE_SOURCE_STATES_VALUE,
		1'b1,
		1'b1,
		AUX_CURRENT_VALUE,
		1'b0,
		1'b0,
		1'b0,
		revision};

	// ==========================================================
	// control/status: wake status, data scale/select and reserved read zero
	assign ctrlStatusWord = {7'h00,
		wakeEnableScratch,
		4'h0,
		revisionSelect,
		1'b0,
		powerState};

endmodule : pmcap_word_compose

// ===== rtl/pmcap_regs.sv
// power-management capability registers in configuration space
//
// Contract
// - capability identifier at 50h is read-only and returns 01h.
// - next pointer at 51h is read-only and returns 60h.
// - capabilities bits 15:11 read all zeros.
// - capabilities bit 10 always reads one.
// - capabilities bit 9 always reads one.
// - capabilities bits 8:6 read zero.
// - capabilities bit 5 reads zero.
// - capabilities reserved bit 4 reads zero.
// - capabilities bit 3 reads zero.
// - revision field is 010b or 011b following the revision-select bit.
// - capabilities word is read-only, 0603h at default with revision-select set.
// - hot-off to fully-on transition causes no internal reset.
// - control/status mixes read-only and writable fields, resets to 0008h with revision-select set, 0000h with it clear.
// - power-state bits 1:0 writable: 00 on, 01/10 intermediate, 11 hot-off.
// - control/status bit 3 reads the revision-select bit.
// - control/status bit 8 is a writable scratch bit, default zero.
// - control/status bits 15:9, 7:4 and 2 read zero.
`timescale 1ns/1ps

module pmcap_regs
	import pmcap_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration access
	input wire pmcap_cfg_req_s cfgReq,
	output logic [31:0] cfgRdData,
	output logic cfgRdValid,
	// general-control revision select, same clock domain
	input wire logic revisionSelect,
	// state to the rest of the device
	output pmcap_power_state_e powerState,
	output logic wakeEnableScratch
);

	// ==========================================================
	// address decode
	wire logic hitCap;
	wire logic hitCtrl;
	assign hitCap = (cfgReq.dwAddr == DW_CAP);
	assign hitCtrl = (cfgReq.dwAddr == DW_CTRL);

	// only the low two bytes of the control dword carry writable bits
	wire logic wrState;
	wire logic wrScratch;
	assign wrState = cfgReq.wr && hitCtrl && cfgReq.byteEn[0];
	assign wrScratch = cfgReq.wr && hitCtrl && cfgReq.byteEn[1];

	// ==========================================================
	// read-value assembly
	logic [15:0] capsWord;
	logic [15:0] ctrlStatusWord;

	pmcap_word_compose u_compose (
		.revisionSelect(revisionSelect),
		.powerState(powerState),
		.wakeEnableScratch(wakeEnableScratch),
		.capsWord(capsWord),
		.ctrlStatusWord(ctrlStatusWord)
	);

	// dword at 50h packs identifier, next pointer and capabilities word
	wire logic [31:0] capDword;
	wire logic [31:0] ctrlDword;
	assign capDword = {capsWord, NEXT_PTR_VALUE, CAP_ID_VALUE};
	// bridge-extension and data bytes are outside this block and read zero here
	assign ctrlDword = {16'h0000, ctrlStatusWord};

	// unmapped dwords answer zero so a stray probe ends the capability walk cleanly
	wire logic [31:0] next_cfgRdData;
	assign next_cfgRdData = hitCap ? capDword : (hitCtrl ? ctrlDword : 32'h0000_0000);

	// ==========================================================
	// writable state
	wire pmcap_power_state_e next_powerState;
	wire logic next_wakeEnableScratch;
	// every encoding is a supported state, so any written value is taken
	assign next_powerState = wrState ? pmcap_power_state_e'(cfgReq.wrData[1:0]) : powerState;
	assign next_wakeEnableScratch = wrScratch ? cfgReq.wrData[CS_SCRATCH_BIT] : wakeEnableScratch;

	// power state and scratch: only rst clears them, a state change never does
	always_ff @(posedge clk) begin
		if (rst) begin
			powerState <= PS_FULL_ON;
			wakeEnableScratch <= WAKE_ENABLE_RESET;
		end else begin
			powerState <= next_powerState;
			wakeEnableScratch <= next_wakeEnableScratch;
		end
	end

	// read answer: one cycle after the request, old value if written alongside
	always_ff @(posedge clk) begin
		if (rst) begin
			cfgRdData <= 32'h0000_0000;
			cfgRdValid <= 1'b0;
		end else begin
			cfgRdData <= cfgReq.rd ? next_cfgRdData : cfgRdData;
			cfgRdValid <= cfgReq.rd;
		end
	end

	// ==========================================================
	// assertions
	sequence s_rd_cap;
		cfgReq.rd && hitCap;
	endsequence

	sequence s_rd_ctrl;
		cfgReq.rd && hitCtrl;
	endsequence

	sequence s_hot_to_on;
		powerState == PS_HOT_OFF ##0 wrState && cfgReq.wrData[1:0] == PS_FULL_ON;
	endsequence

	property p_id_read;
		@(posedge clk) disable iff (rst) s_rd_cap |=> cfgRdValid && cfgRdData[7:0] == CAP_ID_VALUE;
	endproperty
	a_id_read: assert property (p_id_read) else $error("capability identifier wrong");

	property p_next_read;
		@(posedge clk) disable iff (rst) s_rd_cap |=> cfgRdData[15:8] == NEXT_PTR_VALUE;
	endproperty
	a_next_read: assert property (p_next_read) else $error("next pointer wrong");

	property p_wake_states;
		@(posedge clk) disable iff (rst) s_rd_cap |=> cfgRdData[31:27] == 5'h00;
	endproperty
	a_wake_states: assert property (p_wake_states) else $error("wake source states not zero");

	property p_low_states;
		@(posedge clk) disable iff (rst) s_rd_cap |=> cfgRdData[26] && cfgRdData[25];
	endproperty
	a_low_states: assert property (p_low_states) else $error("low-power state flags not set");

	property p_caps_zero;
		@(posedge clk) disable iff (rst) s_rd_cap |=> cfgRdData[24:19] == 6'h00;
	endproperty
	a_caps_zero: assert property (p_caps_zero) else $error("caps zero fields not zero");

	property p_revision;
		@(posedge clk) disable iff (rst)
			s_rd_cap |=> cfgRdData[18:16] == ($past(revisionSelect) ? REVISION_SELECTED : REVISION_BASE);
	endproperty
	a_revision: assert property (p_revision) else $error("revision field mismatch");

	// the printed default assumes the revision select at its default of one (revision 011b)
	property p_caps_default;
		@(posedge clk) disable iff (rst) s_rd_cap ##0 revisionSelect |=> cfgRdData[31:16] == CAPS_RESET;
	endproperty
	a_caps_default: assert property (p_caps_default) else $error("capabilities word not 0603h");

	// bit 3 follows the revision select, so 0008h only shows with the select high
	property p_reset_value;
		@(posedge clk) disable iff (rst)
			$past(rst) ##0 revisionSelect |-> ctrlStatusWord == CTRL_STATUS_RESET && powerState == PS_FULL_ON;
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("control/status reset value wrong");

	property p_no_reset_on_wake;
		@(posedge clk) disable iff (rst)
			s_hot_to_on ##0 !wrScratch |=> powerState == PS_FULL_ON && wakeEnableScratch == $past(wakeEnableScratch);
	endproperty
	a_no_reset_on_wake: assert property (p_no_reset_on_wake) else $error("context lost on hot-off exit");

	property p_state_write;
		@(posedge clk) disable iff (rst) wrState |=> powerState == $past(cfgReq.wrData[1:0]) ##1 $stable(powerState) || $past(wrState);
	endproperty
	a_state_write: assert property (p_state_write) else $error("power state write not taken");

	property p_ctrl_read;
		@(posedge clk) disable iff (rst)
			s_rd_ctrl |=> cfgRdData[3] == $past(revisionSelect) && cfgRdData[1:0] == $past(powerState);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control/status readback wrong");

	property p_scratch;
		@(posedge clk) disable iff (rst) wrScratch |=> wakeEnableScratch == $past(cfgReq.wrData[CS_SCRATCH_BIT]);
	endproperty
	a_scratch: assert property (p_scratch) else $error("scratch bit write not taken");

	property p_ctrl_zero;
		@(posedge clk) disable iff (rst)
			s_rd_ctrl |=> cfgRdData[31:9] == 23'h0 && cfgRdData[7:4] == 4'h0 && !cfgRdData[2];
	endproperty
	a_ctrl_zero: assert property (p_ctrl_zero) else $error("control/status zero bits set");

	property p_ro_write;
		@(posedge clk) disable iff (rst)
			cfgReq.wr && !wrState && !wrScratch |=> $stable(powerState) && $stable(wakeEnableScratch);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write changed state");

endmodule : pmcap_regs

// ===== test/pmcap_regs_tb.sv
// self-checking testbench for the power-management capability registers
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
	$display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end

module pmcap_regs_tb
	import pmcap_pkg::*;
;
	// ==========================================================
	// clock, reset and design hookup
	logic clk = 1'b0;
	logic rst = 1'b1;
	pmcap_cfg_req_s req = '0;
	logic [31:0] rdData;
	logic rdValid;
	logic revSel = 1'b0;
	pmcap_power_state_e powerState;
	logic scratch;
	logic [31:0] d;
	int failures = 0;
	int checks = 0;
	int cycles = 0;

	always #5 clk = ~clk;

	pmcap_regs uut (
		.clk(clk),
		.rst(rst),
		.cfgReq(req),
		.cfgRdData(rdData),
		.cfgRdValid(rdValid),
		.revisionSelect(revSel),
		.powerState(powerState),
		.wakeEnableScratch(scratch)
	);

	// ==========================================================
	// bus tasks
	// a missing valid pulse turns the data unknown so the compare fails
	task automatic cfg_read(input logic [5:0] dw, output logic [31:0] data);
		@(posedge clk);
		req.rd <= 1'b1;
		req.dwAddr <= dw;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		data = rdValid ? rdData : 32'hxxxx_xxxx;
	endtask : cfg_read

	task automatic cfg_write(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd);
		@(posedge clk);
		req.wr <= 1'b1;
		req.dwAddr <= dw;
		req.byteEn <= be;
		req.wrData <= wd;
		@(posedge clk);
		req.wr <= 1'b0;
		#1;
	endtask : cfg_write

	// ==========================================================
	// scenarios
	// fixed fields with revision select low, then high
	task automatic t_fixed();
		cfg_read(DW_CAP, d);
		`CHK(d[15:0], 16'h6001)
		`CHK(d[31:19], 13'h00c0)
		`CHK(d[18:16], 3'h2)
		cfg_read(DW_CTRL, d);
		`CHK(d, 32'h0000_0000)
		@(posedge clk);
		revSel <= 1'b1;
		cfg_read(DW_CAP, d);
		`CHK(d, 32'h0603_6001)
		cfg_read(DW_CTRL, d);
		`CHK(d, 32'h0000_0008)
		cfg_read(6'h3f, d);
		`CHK(d, 32'h0000_0000)
	endtask : t_fixed

	// all-ones writes into read-only places change nothing
	task automatic t_ro_writes();
		cfg_write(DW_CAP, 4'hf, 32'hffff_ffff);
		cfg_write(DW_CTRL, 4'hf, 32'hffff_fefc);
		cfg_read(DW_CAP, d);
		`CHK(d, 32'h0603_6001)
		cfg_read(DW_CTRL, d);
		`CHK(d, 32'h0000_0008)
		`CHK({powerState, scratch}, 3'h0)
	endtask : t_ro_writes

	// every power state, scratch alternating, lanes gated separately
	task automatic t_states();
		for (int s = 0; s < 4; s++) begin
			cfg_write(DW_CTRL, 4'h3, {23'h0, s[0], 6'h0, s[1:0]});
			`CHK(powerState, s[1:0])
			cfg_read(DW_CTRL, d);
			`CHK(d, {23'h0, s[0], 6'h2, s[1:0]})
		end
		// lane 1 alone: state must stay hot-off
		cfg_write(DW_CTRL, 4'h2, 32'h0000_0100);
		`CHK({powerState, scratch}, 3'h7)
		// hot-off back to on keeps the scratch bit, no internal reset
		cfg_write(DW_CTRL, 4'h1, 32'h0000_0000);
		`CHK({powerState, scratch}, 3'h1)
		cfg_read(DW_CTRL, d);
		`CHK(d, 32'h0000_0108)
	endtask : t_states

	// read and write in one cycle: read sees the old value
	task automatic t_same_cycle();
		@(posedge clk);
		req.rd <= 1'b1;
		req.wr <= 1'b1;
		req.dwAddr <= DW_CTRL;
		req.byteEn <= 4'h1;
		req.wrData <= 32'h0000_0002;
		@(posedge clk);
		req.rd <= 1'b0;
		req.wr <= 1'b0;
		#1;
		`CHK(rdData, 32'h0000_0108)
		`CHK(powerState, PS_LOW2)
	endtask : t_same_cycle

	// reset in mid-run restores the defaults
	task automatic t_rereset();
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		cfg_read(DW_CTRL, d);
		`CHK(d, 32'h0000_0008)
		`CHK({powerState, scratch}, 3'h0)
	endtask : t_rereset

	// ==========================================================
	// run control
	task automatic end_sim();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	// watchdog: the sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			end_sim();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_fixed();
		t_ro_writes();
		t_states();
		t_same_cycle();
		t_rereset();
		end_sim();
	end
endmodule : pmcap_regs_tb
